// ---- core/sss_top.sv ----
// Selector store, flags save, I/O permission and stack pop checks
// Behaviour
// [RULE1] Task area selectors stored as zero-extended words
// [RULE2] Sixteen-bit area saves only low flags
// [RULE3] Return to sixteen-bit task clears virtual mode
// [RULE4] Software uses 32-bit areas for 32-bit code
// [RULE5] Permission lookup uses full 32-bit address
// [RULE6] Map base plus offset over limit faults
// [RULE7] Software keeps map base below 0DFFF
// [RULE8] Area access order and fault address vary
// [RULE9] Selector push writes four bytes, upper zero
// [RULE10] Selector pop reads four, drops upper two
// [RULE11] Pop beyond limit minus four: stack fault
// [RULE12] Selector sits in low two bytes
`timescale 1ns/1ps
module sss_top
	import sss_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	// Task save request
	input  wire logic        save_start_i,
	input  wire logic        tsa_is32_i,
	input  wire logic [31:0] tsa_base_i,
	input  wire logic [31:0] flags_word_i,
	input  wire logic [95:0] sels_i,
	// Task restore
	input  wire logic        restore_i,
	input  wire logic        rest_is32_i,
	input  wire logic [31:0] rest_flags_i,
	// I/O permission check
	input  wire logic        io_chk_i,
	input  wire logic [31:0] io_map_base_i,
	input  wire logic [31:0] io_offset_i,
	input  wire logic [31:0] tsa_limit_i,
	// Stack operations
	input  wire logic        push_i,
	input  wire logic        pop_i,
	input  wire logic [15:0] push_sel_i,
	input  wire logic [31:0] stack_pointer_i,
	input  wire logic [31:0] stack_limit_i,
	input  wire logic [31:0] mem_rdata_i,
	input  wire logic        mem_rvalid_i,
	// Memory port
	output logic             mem_we_o,
	output logic             mem_re_o,
	output logic [31:0]      mem_addr_o,
	output logic [31:0]      mem_wdata_o,
	// Results
	output logic             busy_o,
	output logic [31:0]      flags_word_o,
	output logic             protection_fault_o,
	output logic             stack_fault_o,
	output logic [15:0]      pop_sel_o,
	output logic             pop_done_o
);
	typedef struct packed {
		sss_state_type st;
		logic [2:0]    idx;
		logic          is32;
		logic [31:0]   base;
		logic [31:0]   rd_addr;
		logic          re;
		logic [31:0]   flags;
		logic          gp;
		logic          ss;
		logic [15:0]   pop_sel;
		logic          pop_done;
		logic          busy;
		logic [31:0]   maddr;
	} sss_top_type;

	sss_top_type r, next_r;
	sss_mem_if   wr ();

	logic [SEL_COUNT*16-1:0] sel_vec;
	logic [15:0]             sel_pick;
	logic [32:0]             io_sum;
	logic [32:0]             pop_end;

	assign sel_vec  = sels_i;
	assign sel_pick = sel_vec[16*r.idx +: 16];
	// Carry kept so the lookup never wraps
	assign io_sum   = {1'b0, io_map_base_i} + {1'b0, io_offset_i}; // [RULE5]
	assign pop_end  = {1'b0, stack_pointer_i} + {1'b0, STACK_SLOT_SIZE};

	always_comb begin
		next_r          = r;
		next_r.gp       = 1'b0;
		next_r.ss       = 1'b0;
		next_r.pop_done = 1'b0;
		next_r.re       = 1'b0;
		wr.req          = 1'b0;
		wr.addr         = '0;
		wr.sel          = '0;
		wr.is_sel       = 1'b0;
		wr.raw          = '0;
		if (io_chk_i && (io_sum > {1'b0, tsa_limit_i})) begin
			next_r.gp = 1'b1; // [RULE6]
		end
		if (restore_i) begin
			next_r.flags = rest_flags_i;
			if (!rest_is32_i) begin
				// Upper half never saved, so virtual mode stays off
				next_r.flags = {16'h0000, rest_flags_i[15:0]}; // [RULE3]
			end
		end
		case (r.st)
			ST_IDLE: begin
				next_r.idx = '0;
				if (save_start_i) begin
					next_r.st    = ST_FLAGS;
					next_r.is32  = tsa_is32_i;
					next_r.base  = tsa_base_i;
					next_r.flags = flags_word_i;
				end else if (push_i) begin
					next_r.st = ST_PUSH;
				end else if (pop_i) begin
					if (pop_end > {1'b0, stack_limit_i}) begin
						next_r.ss = 1'b1; // [RULE11]
					end else begin
						next_r.st      = ST_POP;
						next_r.rd_addr = stack_pointer_i;
						next_r.re      = 1'b1;
					end
				end
			end
			ST_FLAGS: begin
				wr.req = 1'b1;
				if (r.is32) begin
					wr.addr = r.base + TSA_FLAGS_OFS32;
					wr.raw  = r.flags;
				end else begin
					wr.addr = r.base + TSA_FLAGS_OFS16;
					wr.raw  = {16'h0000, r.flags[15:0]}; // [RULE2]
				end
				next_r.st = ST_SELS;
			end
			ST_SELS: begin
				// Fixed ascending order; fault address depends on it
				wr.req    = 1'b1; // [RULE8]
				wr.is_sel = 1'b1;
				wr.sel    = sel_pick;
				wr.addr   = r.base + TSA_SEL_OFFSET + {27'h0, r.idx, 2'b00};
				next_r.idx = r.idx + 3'h1;
				if (r.idx == SEL_IDX_LAST) begin
					next_r.st = ST_IDLE;
				end
			end
			ST_PUSH: begin
				wr.req    = 1'b1;
				wr.is_sel = 1'b1; // [RULE9]
				wr.sel    = push_sel_i;
				wr.addr   = stack_pointer_i - STACK_SLOT_SIZE;
				next_r.st = ST_IDLE;
			end
			ST_POP: begin
				next_r.st = ST_POPW;
			end
			ST_POPW: begin
				if (mem_rvalid_i) begin
					next_r.pop_sel  = mem_rdata_i[15:0]; // [RULE10]
					next_r.pop_done = 1'b1;
					next_r.st       = ST_IDLE;
				end
			end
			default: begin
				next_r.st = ST_IDLE;
			end
		endcase
		// Address and busy registered so the pins come from flip-flops
		next_r.busy = (next_r.st != ST_IDLE);
		if (next_r.re) begin
			next_r.maddr = next_r.rd_addr;
		end else if (wr.req) begin
			next_r.maddr = wr.addr;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r       <= '0;
			r.st    <= ST_IDLE;
			r.flags <= {16'h0000, FLAGS_RESET};
		end else begin
			r <= next_r;
		end
	end

	logic        fmt_we;

	sss_wr_fmt u_fmt (
		.mclk_i (mclk_i),
		.rstn_i (rstn_i),
		.wr     (wr),
		.we_o   (fmt_we),
		.addr_o (),
		.data_o (mem_wdata_o)
	);

	assign mem_we_o           = fmt_we;
	assign mem_re_o           = r.re;
	assign mem_addr_o         = r.maddr;
	assign busy_o             = r.busy;
	assign flags_word_o       = r.flags;
	assign protection_fault_o = r.gp;
	assign stack_fault_o      = r.ss;
	assign pop_sel_o          = r.pop_sel;
	assign pop_done_o         = r.pop_done;
endmodule : sss_top

// ---- core/sss_pkg.sv ----
// Package: constants and types for the selector state store checks block
package sss_pkg;
	localparam logic [31:0] SEL_UPPER_ZERO  = 32'h0000_0000;
	localparam int          SEL_LO_W        = 16;
	localparam logic [31:0] STACK_SLOT_SIZE = 32'h0000_0004;
	localparam int          VM_FLAG_POS     = 17;
	localparam logic [15:0] FLAGS_RESET     = 16'h0002;
	localparam int          SEL_COUNT       = 6;
	localparam logic [31:0] TSA_SEL_OFFSET  = 32'h0000_0048;
	localparam logic [31:0] TSA_FLAGS_OFS32 = 32'h0000_0024;
	localparam logic [31:0] TSA_FLAGS_OFS16 = 32'h0000_0010;
	localparam logic [2:0]  SEL_IDX_LAST    = 3'h5;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_FLAGS = 3'b001,
		ST_SELS  = 3'b010,
		ST_PUSH  = 3'b011,
		ST_POP   = 3'b100,
		ST_POPW  = 3'b101
	} sss_state_type;

	// Selector widened to a stored word
	function automatic logic [31:0] sss_widen(input logic [15:0] sel);
		return {SEL_UPPER_ZERO[31:SEL_LO_W], sel};
	endfunction : sss_widen
endpackage : sss_pkg

// ---- core/sss_mem_if.sv ----
// Interface: memory write channel between sequencer and word formatter
`timescale 1ns/1ps
interface sss_mem_if;
	logic        req;
	logic [31:0] addr;
	logic [15:0] sel;
	logic        is_sel;
	logic [31:0] raw;
	modport src (output req, output addr, output sel, output is_sel, output raw);
	modport dst (input req, input addr, input sel, input is_sel, input raw);
endinterface : sss_mem_if

// ---- core/sss_wr_fmt.sv ----
// Write formatter: registers each memory write word with selector widening
`timescale 1ns/1ps
module sss_wr_fmt
	import sss_pkg::*;
(
	// Clock and reset
	input  wire logic  mclk_i,
	input  wire logic  rstn_i,
	// Request side
	sss_mem_if.dst     wr,
	// Memory side
	output logic        we_o,
	output logic [31:0] addr_o,
	output logic [31:0] data_o
);
	typedef struct packed {
		logic        we;
		logic [31:0] addr;
		logic [31:0] data;
	} sss_fmt_type;

	sss_fmt_type r, next_r;

	always_comb begin
		next_r      = r;
		next_r.we   = wr.req;
		if (wr.req) begin
			next_r.addr = wr.addr;
			next_r.data = wr.is_sel ? sss_widen(wr.sel) : wr.raw; // [RULE1] [RULE9] [RULE12]
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign we_o   = r.we;
	assign addr_o = r.addr;
	assign data_o = r.data;
endmodule : sss_wr_fmt

// ---- tb/sss_sva.sv ----
// Port checker for the selector store block
`timescale 1ns/1ps
module sss_sva
	import sss_pkg::*;
(
	// Strobes and flags
	input wire logic mclk_i, rstn_i, save_start_i, tsa_is32_i, restore_i, rest_is32_i,
	input wire logic io_chk_i, push_i, pop_i, mem_rvalid_i, mem_we_o, busy_o,
	input wire logic protection_fault_o, stack_fault_o, pop_done_o,
	// Words
	input wire logic [31:0] tsa_base_i, io_map_base_i, io_offset_i, tsa_limit_i,
	input wire logic [31:0] stack_pointer_i, stack_limit_i, mem_rdata_i,
	input wire logic [31:0] mem_addr_o, mem_wdata_o, flags_word_o,
	input wire logic [15:0] push_sel_i, pop_sel_o
);
	logic [15:0] rd_lo;
	assign rd_lo = mem_rdata_i[15:0];
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	sequence save_go;
		save_start_i && !busy_o;
	endsequence
	sequence sel_wr;
		mem_we_o && mem_wdata_o[31:16] == 16'h0000;
	endsequence
	flags_save_a: assert property (save_go |-> ##2 mem_we_o && mem_addr_o ==
		$past(tsa_base_i, 2) + ($past(tsa_is32_i, 2) ? TSA_FLAGS_OFS32 : TSA_FLAGS_OFS16))
		else $error("flags address");
	flags_half_a: assert property (save_go ##0 !tsa_is32_i |-> ##2 sel_wr)
		else $error("flags upper half");
	sel_store_a: assert property (save_go |-> ##3 sel_wr [*6])
		else $error("selector word");
	io_fault_a: assert property (protection_fault_o == ($past(io_chk_i) &&
		{1'b0, $past(io_map_base_i)} + $past(io_offset_i) > {1'b0, $past(tsa_limit_i)}))
		else $error("permission fault");
	pop_fault_a: assert property (pop_i && !busy_o && !save_start_i && !push_i |=>
		stack_fault_o == ({1'b0, $past(stack_pointer_i)} + 33'h4 > {1'b0, $past(stack_limit_i)}))
		else $error("stack fault");
	pop_low_a: assert property (mem_rvalid_i && busy_o |=> pop_done_o &&
		pop_sel_o == $past(rd_lo)) else $error("popped selector");
	push_word_a: assert property (push_i && !busy_o && !save_start_i |-> ##2 mem_we_o &&
		mem_wdata_o == {16'h0000, $past(push_sel_i, 2)} && mem_addr_o == $past(stack_pointer_i, 2) - 32'h4)
		else $error("pushed word");
	rest_vm_a: assert property (restore_i && !rest_is32_i |=> flags_word_o[31:16] == 16'h0000)
		else $error("restored flags");
endmodule : sss_sva
bind sss_top sss_sva u_sss_sva(.*);

// ---- tb/sss_mem_model.sv ----
// Memory model holding task area and stack words
`timescale 1ns/1ps
module sss_mem_model(
	input wire logic mclk_i, we_i, re_i, slow_i,
	input wire logic [31:0] addr_i, wdata_i,
	output logic rvalid_o = 1'b0,
	output logic [31:0] rdata_o = 32'h0
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] a;
	always @(posedge mclk_i) begin
		if (we_i)
			mem[addr_i] = wdata_i;
		if (re_i) begin
			a = addr_i;
			repeat (slow_i ? 3 : 0) @(posedge mclk_i);
			rvalid_o <= 1'b1;
			// Unwritten words carry a nonzero upper half
			rdata_o <= mem.exists(a) ? mem[a] : {16'hFFFF, a[17:2]};
			@(posedge mclk_i);
			rvalid_o <= 1'b0;
			rdata_o <= ~rdata_o;
		end
	end
endmodule : sss_mem_model

// ---- tb/testbench.sv ----
// Self-checking bench for the selector store block
`timescale 1ns/1ps
module testbench;
	import sss_pkg::*;
	logic mclk_i = 0, rstn_i = 0, save_start_i = 0, tsa_is32_i = 0, restore_i = 0, slow = 0;
	logic rest_is32_i = 0, io_chk_i = 0, push_i = 0, pop_i = 0;
	logic [31:0] tsa_base_i = 0, flags_word_i = 0, rest_flags_i = 0, io_map_base_i = 0;
	logic [31:0] io_offset_i = 0, tsa_limit_i = 0, stack_pointer_i = 0, stack_limit_i = 0;
	logic [95:0] sels_i = 0;
	logic [15:0] push_sel_i = 0;
	wire logic mem_rvalid_i, mem_we_o, mem_re_o, busy_o, protection_fault_o, stack_fault_o;
	wire logic pop_done_o;
	wire logic [31:0] mem_rdata_i, mem_addr_o, mem_wdata_o, flags_word_o;
	wire logic [15:0] pop_sel_o;
	int miscompares = 0, num_checks = 0, cyc = 0;
	logic [31:0] r = 32'h7;
	logic [63:0] wq[$];
	logic [15:0] pq[$];
	logic [1:0] fq[$];
	logic [31:0] rq[$];
	sss_top u_sss_top(.*);
	sss_mem_model u_sss_mem_model(.mclk_i, .we_i(mem_we_o), .re_i(mem_re_o), .slow_i(slow),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
	initial forever #12.5 mclk_i = ~mclk_i;
	function automatic logic [31:0] lf(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lf
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	// Pulse one strobe, then let the block settle back to idle
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge mclk_i) s = 1'b0;
		for (int i = 0; i < 40 && busy_o !== 1'b0; i++) @(negedge mclk_i);
		repeat (2) @(negedge mclk_i);
	endtask : pulse
	always @(negedge mclk_i) begin
		if (mem_we_o === 1'b1)
			chk("write", wq.size() ? wq.pop_front() : 'x, {mem_addr_o, mem_wdata_o});
		if (pop_done_o === 1'b1)
			chk("pop", pq.size() ? pq.pop_front() : 'x, pop_sel_o);
		if (mem_re_o === 1'b1)
			chk("read", rq.size() ? rq.pop_front() : 'x, mem_addr_o);
		if (protection_fault_o === 1'b1 || stack_fault_o === 1'b1)
			chk("fault", fq.size() ? fq.pop_front() : 'x, {protection_fault_o, stack_fault_o});
	end
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		repeat (16) @(negedge mclk_i);
		rstn_i = 1'b1;
		for (int t = 0; t < 2; t++) begin
			r = lf(r);
			tsa_base_i = r & 32'hFFFF_FF00;
			flags_word_i = lf(r) | 32'h0002_0000;
			sels_i = {lf(flags_word_i), r, flags_word_i};
			tsa_is32_i = (t == 0);
			wq.push_back({tsa_base_i + (t == 0 ? TSA_FLAGS_OFS32 : TSA_FLAGS_OFS16),
				t == 0 ? flags_word_i : {16'h0000, flags_word_i[15:0]}});
			for (int i = 0; i < 6; i++)
				wq.push_back({tsa_base_i + TSA_SEL_OFFSET + 4 * i, 16'h0000, sels_i[16 * i +: 16]});
			pulse(save_start_i);
			rest_is32_i = t[0];
			rest_flags_i = 32'h0002_0002 | r;
			pulse(restore_i);
			chk("flags", t ? rest_flags_i : {16'h0000, rest_flags_i[15:0]}, flags_word_o);
			$display("save test %0d done", t);
		end
		for (int t = 0; t < 3; t++) begin
			io_map_base_i = t == 2 ? 32'hFFFF_FFF0 : 32'h0000_1000;
			io_offset_i = t == 2 ? 32'h0000_0020 : 32'h0000_0010 + t;
			tsa_limit_i = t == 2 ? 32'hFFFF_FFFF : 32'h0000_1010;
			if (t > 0)
				fq.push_back(2'b10);
			pulse(io_chk_i);
		end
		$display("permission test done");
		stack_limit_i = 32'h0000_2000;
		for (int t = 0; t < 2; t++) begin
			slow = t[0];
			r = lf(r);
			push_sel_i = r[15:0];
			stack_pointer_i = 32'h0000_1F00 + 8 * t;
			wq.push_back({stack_pointer_i - 32'h4, 16'h0000, push_sel_i});
			pulse(push_i);
			stack_pointer_i = stack_pointer_i - 32'h4;
			pq.push_back(push_sel_i);
			rq.push_back(stack_pointer_i);
			pulse(pop_i);
		end
		stack_pointer_i = 32'h0000_1FFC;
		pq.push_back(16'h07FF);
		rq.push_back(stack_pointer_i);
		pulse(pop_i);
		stack_pointer_i = 32'h0000_1FFD;
		fq.push_back(2'b01);
		pulse(pop_i);
		$display("stack test done");
		chk("left", 0, wq.size() + pq.size() + fq.size() + rq.size());
		print_verdict();
	end
endmodule : testbench
